// ### csb_collision_backoff.sv
// collision, retry, backoff and frame completion control with apb access
// Function
// - late collision: set flag, jam, no retry
// - early collision: retry up to eight attempts
// - ninth collision: jam, backoff, disable tx
// - collision shifts count left, ones in
// - count overflow stops channel, sets flag
// - random slot masked by shift count
// - normal mode waits longer of gap, backoff
// - alternate mode waits gap plus backoff
// - missed slot waits whole resolution period
// - retransmit only after gap of idle line
// - gap timing follows line at all times
// - transmitters back off, receivers only detect outside deterministic mode
// - receiver collision stops, maybe aborts frame
// - deterministic: fixed slots, receivers back off
// - tx empty and sent: done, clear enable
// - end flag: rx done, clear enable
// - backoff timer slot-rate, writes ignored
// - slot 63 first, zero waits all
// - jam type picks constant or alternating
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module csb_collision_backoff
   import csb_pkg::*;
#(
   parameter int BIT_DIV = 10,
   parameter int SLOT_BITS = 64
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link side
   input wire csb_link_in_t linkIn,
   output csb_link_out_t linkOut,
   // enables and alarm seen by the framers
   output logic txEnable,
   output logic rxEnable,
   output logic collisionIrq
);
   // ==========================================================
   // state
   csb_state_t state_r, state_nxt;
   logic txEn_r, txEn_nxt;           // tx_enable
   logic rxEn_r, rxEn_nxt;           // rx_enable_bit
   logic sdlc_r, sdlc_nxt;           // low means collision-detect link
   logic bmLo_r, bmLo_nxt;           // backoff_mode_low
   logic bmHi_r, bmHi_nxt;           // backoff_mode_high
   logic irqEn_r, irqEn_nxt;         // collision alarm enable
   logic [7:0] slot_r, slot_nxt;     // station slot, det, jam type
   logic [7:0] gap_r, gap_nxt;       // interframe_gap in bit times
   logic [7:0] coll_r, coll_nxt;     // collision_shift_count
   logic [3:0] flags_r, flags_nxt;   // sticky status flags
   logic [5:0] jamCnt_r, jamCnt_nxt; // jam bits sent
   logic late_r, late_nxt;           // jam after a late collision
   logic final_r, final_nxt;         // jam after count overflow
   logic [8:0] ifs_r, ifs_nxt;       // interframe gap remaining
   logic [7:0] lfsr_r, lfsr_nxt;     // random source
   csb_link_out_t out_r, out_nxt;
   logic irq_r, irq_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic ready_r, ready_nxt;
   logic err_r, err_nxt;
   // ==========================================================
   // combinational helpers
   logic access, wrEn, mapped, ifsDone, alt, det, csma;
   logic tmrLoad, tmrRun, tmrZero, bitTick;
   logic [7:0] tmrLoadVal, tmrValue, slotWait;

   // gap reload: zero stands for the longest gap
   function automatic logic [8:0] gapLoad(input logic [7:0] g);
      gapLoad = (g == 8'h00) ? CSB_GAP_ZERO : {1'b0, g};
   endfunction

   // address decode shared by write and error paths
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == CSB_CTRL_OFS) || (a == CSB_SLOT_OFS) ||
         (a == CSB_GAP_OFS) || (a == CSB_COLL_OFS) ||
         (a == CSB_BKOFF_OFS) || (a == CSB_STAT_OFS);
   endfunction

   assign access = psel && penable && ready_r;
   assign wrEn = access && pwrite && isMapped(paddr);
   assign mapped = isMapped(paddr);
   assign ifsDone = (ifs_r == 9'h000);
   assign alt = bmLo_r && bmHi_r;
   assign det = slot_r[CSB_DET_BIT];
   assign csma = !sdlc_r;

   // deterministic slot order, random slot under mask
   assign slotWait = det ? ((slot_r[5:0] == 6'h00) ? CSB_RES_SLOTS :
                            (CSB_TOP_SLOT - {2'b00, slot_r[5:0]})) :
                     (lfsr_r & coll_r);

   // ==========================================================
   // backoff timer and tick divider
   csb_slot_timer #(
      .BIT_DIV(BIT_DIV),
      .SLOT_BITS(SLOT_BITS)
   ) u_timer (
      .clk(clk),
      .srst(srst),
      .load(tmrLoad),
      .loadVal(tmrLoadVal),
      .run(tmrRun),
      .bitTick(bitTick),
      .zero(tmrZero),
      .value(tmrValue)
   );

   // ==========================================================
   // apb answer: one wait cycle, then pready for one cycle
   always_comb begin
      ready_nxt = psel && penable && !ready_r;
      err_nxt = psel && penable && !ready_r && !mapped;
      rdata_nxt = 32'h0000_0000;
      // unmapped or write access reads as zero
      if (psel && penable && !ready_r && !pwrite) begin
         case (paddr)
            CSB_CTRL_OFS: rdata_nxt[5:0] =
               {irqEn_r, bmHi_r, bmLo_r, sdlc_r, rxEn_r, txEn_r};
            CSB_SLOT_OFS: rdata_nxt[7:0] = slot_r;
            CSB_GAP_OFS: rdata_nxt[7:0] = gap_r;
            CSB_COLL_OFS: rdata_nxt[7:0] = coll_r;
            CSB_BKOFF_OFS: rdata_nxt[7:0] = tmrValue;
            CSB_STAT_OFS: rdata_nxt[3:0] = flags_r;
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ready_r <= 1'b0;
         err_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ready_r <= ready_nxt;
         err_r <= err_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================
   // interframe gap and random source
   always_comb begin
      lfsr_nxt = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^
                  lfsr_r[3]};
      ifs_nxt = ifs_r;
      // gap tracks the line even when not sending
      if (linkIn.lineBusy) begin
         ifs_nxt = gapLoad(gap_r);
      end else if (bitTick && !ifsDone) begin
         ifs_nxt = ifs_r - 9'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         lfsr_r <= CSB_LFSR_SEED;
         ifs_r <= 9'h000;
      end else begin
         lfsr_r <= lfsr_nxt;
         ifs_r <= ifs_nxt;
      end
   end

   // ==========================================================
   // software writes, then hardware events (hardware wins)
   always_comb begin
      state_nxt = state_r;
      txEn_nxt = txEn_r;
      rxEn_nxt = rxEn_r;
      sdlc_nxt = sdlc_r;
      bmLo_nxt = bmLo_r;
      bmHi_nxt = bmHi_r;
      irqEn_nxt = irqEn_r;
      slot_nxt = slot_r;
      gap_nxt = gap_r;
      coll_nxt = coll_r;
      flags_nxt = flags_r;
      jamCnt_nxt = jamCnt_r;
      late_nxt = late_r;
      final_nxt = final_r;
      tmrLoad = 1'b0;
      tmrLoadVal = slotWait;
      tmrRun = 1'b0;
      out_nxt = out_r;
      out_nxt.rxHalt = 1'b0;
      if (wrEn) begin
         case (paddr)
            CSB_CTRL_OFS: begin
               txEn_nxt = pwdata[CSB_TXEN_BIT];
               rxEn_nxt = pwdata[CSB_RXEN_BIT];
               sdlc_nxt = pwdata[CSB_SDLC_BIT];
               bmLo_nxt = pwdata[CSB_BMLO_BIT];
               bmHi_nxt = pwdata[CSB_BMHI_BIT];
               irqEn_nxt = pwdata[CSB_IRQEN_BIT];
               if (pwdata[CSB_TXEN_BIT] && !txEn_r) begin
                  flags_nxt[CSB_TXCOLL_BIT] = 1'b0;
                  flags_nxt[CSB_TXDONE_BIT] = 1'b0;
               end
               if (pwdata[CSB_RXEN_BIT] && !rxEn_r) begin
                  flags_nxt[CSB_RXABT_BIT] = 1'b0;
                  flags_nxt[CSB_RXDONE_BIT] = 1'b0;
               end
            end
            CSB_SLOT_OFS: slot_nxt = pwdata[7:0];
            CSB_GAP_OFS: gap_nxt = pwdata[7:0];
            CSB_COLL_OFS: coll_nxt = pwdata[7:0];
            CSB_STAT_OFS: flags_nxt = flags_r & ~pwdata[3:0];
            // backoff timer writes have no effect
            default: ;
         endcase
      end
      case (state_r)
         ST_IDLE: begin
            if (csma && det && linkIn.collision && linkIn.rxActive) begin
               tmrLoad = 1'b1;
               final_nxt = 1'b0;
               state_nxt = ST_BACKOFF;
            // start only after an idle gap
            end else if (txEn_r && !linkIn.txFifoEmpty && ifsDone &&
                         !linkIn.lineBusy) begin
               state_nxt = ST_SEND;
            end
         end
         ST_SEND: begin
            if (csma && linkIn.collision) begin
               // shift left, one into the low bit
               coll_nxt = {coll_r[6:0], 1'b1};
               jamCnt_nxt = 6'h00;
               late_nxt = !linkIn.txPreamble;
               final_nxt = coll_r[7];
               // late collision or overflow flags it
               if (!linkIn.txPreamble || coll_r[7]) begin
                  flags_nxt[CSB_TXCOLL_BIT] = 1'b1;
               end
               state_nxt = ST_JAM;
            // tx_fifo empty and last byte out
            end else if (linkIn.txFifoEmpty && linkIn.txLastSent) begin
               flags_nxt[CSB_TXDONE_BIT] = 1'b1;
               txEn_nxt = 1'b0;
               state_nxt = ST_IDLE;
            end else if (!txEn_r) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_JAM: begin
            // constant jam or one toggle per bit
            out_nxt.jamLevel = slot_r[CSB_JAMDC_BIT] ? 1'b1 :
                               (out_r.jamLevel ^ bitTick);
            if (bitTick) begin
               jamCnt_nxt = jamCnt_r + 6'h01;
            end
            if (bitTick && jamCnt_r == CSB_JAM_BITS - 6'h01) begin
               if (late_r) begin
                  txEn_nxt = 1'b0;
                  state_nxt = ST_IDLE;
               end else begin
                  tmrLoad = 1'b1;
                  state_nxt = ST_BACKOFF;
               end
            end
         end
         ST_BACKOFF: begin
            // alternate holds backoff until gap ends, else both run
            tmrRun = alt ? ifsDone : 1'b1;
            if (tmrZero && ifsDone) begin
               if (final_r) begin
                  txEn_nxt = 1'b0;
                  state_nxt = ST_IDLE;
               end else if (!txEn_r) begin
                  state_nxt = ST_IDLE;
               // not ready at the slot: sit out resolution
               end else if (linkIn.txFifoEmpty || linkIn.lineBusy) begin
                  tmrLoad = 1'b1;
                  tmrLoadVal = CSB_RES_SLOTS;
                  state_nxt = ST_RESWAIT;
               end else begin
                  state_nxt = ST_SEND;
               end
            // software abort of a pending retry
            end else if (!txEn_r && !det) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_RESWAIT: begin
            tmrRun = 1'b1;
            if (tmrZero || !txEn_r) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      if (csma && linkIn.collision && linkIn.rxActive && rxEn_r) begin
         out_nxt.rxHalt = 1'b1;
         if (linkIn.rxFifoHasData) begin
            flags_nxt[CSB_RXABT_BIT] = 1'b1;
            rxEn_nxt = 1'b0;
         end
      end else if (linkIn.rxEof && rxEn_r) begin
         flags_nxt[CSB_RXDONE_BIT] = 1'b1;
         rxEn_nxt = 1'b0;
      end
      out_nxt.txGrant = (state_nxt == ST_SEND);
      out_nxt.jamActive = (state_nxt == ST_JAM);
      irq_nxt = irqEn_nxt && flags_nxt[CSB_TXCOLL_BIT];
   end

   // registers only
   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= ST_IDLE;
         txEn_r <= 1'b0;
         rxEn_r <= 1'b0;
         sdlc_r <= 1'b0;
         bmLo_r <= 1'b0;
         bmHi_r <= 1'b0;
         irqEn_r <= 1'b0;
         slot_r <= 8'h00;
         gap_r <= CSB_GAP_RST;
         coll_r <= 8'h00;
         flags_r <= 4'h0;
         jamCnt_r <= 6'h00;
         late_r <= 1'b0;
         final_r <= 1'b0;
         out_r <= '0;
         irq_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         txEn_r <= txEn_nxt;
         rxEn_r <= rxEn_nxt;
         sdlc_r <= sdlc_nxt;
         bmLo_r <= bmLo_nxt;
         bmHi_r <= bmHi_nxt;
         irqEn_r <= irqEn_nxt;
         slot_r <= slot_nxt;
         gap_r <= gap_nxt;
         coll_r <= coll_nxt;
         flags_r <= flags_nxt;
         jamCnt_r <= jamCnt_nxt;
         late_r <= late_nxt;
         final_r <= final_nxt;
         out_r <= out_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign prdata = rdata_r;
   assign pready = ready_r;
   assign pslverr = err_r;
   assign linkOut = out_r;
   assign txEnable = txEn_r;
   assign rxEnable = rxEn_r;
   assign collisionIrq = irq_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic sendColl;
   assign sendColl = state_r == ST_SEND && csma && linkIn.collision;

   property p_shift;
      sendColl && !wrEn |=> coll_r == {$past(coll_r[6:0]), 1'b1};
   endproperty
   a_shift: assert property (p_shift) else $error("shift count wrong");
   property p_late;
      sendColl && !linkIn.txPreamble |=>
         state_r == ST_JAM && flags_r[CSB_TXCOLL_BIT];
   endproperty
   a_late: assert property (p_late) else $error("late collision missed");
   property p_noretry;
      state_r == ST_JAM && late_r && bitTick &&
         jamCnt_r == CSB_JAM_BITS - 6'h01 |=> state_r == ST_IDLE && !txEn_r;
   endproperty
   a_noretry: assert property (p_noretry) else $error("late retry");
   property p_final;
      state_r == ST_BACKOFF && final_r && tmrZero && ifsDone |=> !txEn_r;
   endproperty
   a_final: assert property (p_final) else $error("tx left on");
   property p_mask;
      state_r == ST_JAM && tmrLoad && !det |-> (tmrLoadVal & ~coll_r) == 0;
   endproperty
   a_mask: assert property (p_mask) else $error("slot not masked");
   property p_alt;
      state_r == ST_BACKOFF && alt && !ifsDone |-> !tmrRun;
   endproperty
   a_alt: assert property (p_alt) else $error("backoff ran in gap");
   property p_gap;
      state_r == ST_IDLE ##1 state_r == ST_SEND |-> $past(ifsDone);
   endproperty
   a_gap: assert property (p_gap) else $error("sent inside gap");
   property p_txdone;
      state_r == ST_SEND && !sendColl && linkIn.txFifoEmpty &&
         linkIn.txLastSent |=> flags_r[CSB_TXDONE_BIT] && !txEn_r ##1
         !linkOut.txGrant;
   endproperty
   a_txdone: assert property (p_txdone) else $error("tx done missed");
   property p_rxdone;
      linkIn.rxEof && rxEn_r && !linkIn.collision |=>
         flags_r[CSB_RXDONE_BIT] && !rxEn_r;
   endproperty
   a_rxdone: assert property (p_rxdone) else $error("rx done missed");
endmodule // csb_collision_backoff
`default_nettype wire

// ### csb_link_model.sv
// far-side model: framer plus the other stations sharing the link
`timescale 1ns/10ps
`default_nettype none
module csb_link_model
   import csb_pkg::*;
#(
   parameter int PRE_CYC = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // commands from the bench
   input wire logic collideReq,
   input wire logic fifoEmpty,
   input wire logic rxAct,
   input wire logic rxData,
   input wire logic rxEnd,
   // link carriers
   input wire csb_link_out_t linkOut,
   output csb_link_in_t linkIn
);
   // ==========
   // cycles since the line was granted, preamble ends after PRE_CYC
   int sendCnt;
   always_ff @(posedge clk) begin
      if (srst || !linkOut.txGrant) begin
         sendCnt <= 0;
      end else begin
         sendCnt <= sendCnt + 1;
      end
   end
   // line always visible, collisions only when commanded
   always_comb begin
      linkIn.lineBusy = linkOut.txGrant | linkOut.jamActive | rxAct;
      linkIn.collision = collideReq;
      linkIn.txPreamble = linkOut.txGrant && (sendCnt < PRE_CYC);
      linkIn.txFifoEmpty = fifoEmpty;
      // last byte counts as gone once the fifo runs dry while sending
      linkIn.txLastSent = linkOut.txGrant & fifoEmpty;
      linkIn.rxActive = rxAct;
      linkIn.rxFifoHasData = rxAct & rxData;
      linkIn.rxEof = rxEnd;
   end
endmodule // csb_link_model
`default_nettype wire

// ### csb_pkg.sv
// shared constants and types for the collision backoff block
package csb_pkg;
   // ==========================================================
   // register offsets (byte addresses on the apb bus)
   localparam logic [7:0] CSB_CTRL_OFS = 8'h00;
   localparam logic [7:0] CSB_SLOT_OFS = 8'h04;
   localparam logic [7:0] CSB_GAP_OFS = 8'h08;
   localparam logic [7:0] CSB_COLL_OFS = 8'h0c;
   localparam logic [7:0] CSB_BKOFF_OFS = 8'h10;
   localparam logic [7:0] CSB_STAT_OFS = 8'h14;
   // ==========================================================
   // control register field positions
   localparam int CSB_TXEN_BIT = 0;
   localparam int CSB_RXEN_BIT = 1;
   localparam int CSB_SDLC_BIT = 2;
   localparam int CSB_BMLO_BIT = 3;
   localparam int CSB_BMHI_BIT = 4;
   localparam int CSB_IRQEN_BIT = 5;
   // slot register: [5:0] station slot, then these two
   localparam int CSB_DET_BIT = 6;
   localparam int CSB_JAMDC_BIT = 7;
   // status flag positions, write one to clear
   localparam int CSB_TXCOLL_BIT = 0;
   localparam int CSB_RXABT_BIT = 1;
   localparam int CSB_TXDONE_BIT = 2;
   localparam int CSB_RXDONE_BIT = 3;
   // ==========================================================
   // reset values and timing counts
   localparam logic [7:0] CSB_GAP_RST = 8'h00;
   localparam logic [7:0] CSB_LFSR_SEED = 8'hff;
   localparam logic [5:0] CSB_JAM_BITS = 6'h20;
   localparam logic [7:0] CSB_RES_SLOTS = 8'h40;
   localparam logic [7:0] CSB_TOP_SLOT = 8'h3f;
   localparam logic [8:0] CSB_GAP_ZERO = 9'h100;
   // ==========================================================
   // link-side carriers from and to the framer
   typedef struct packed {
      logic lineBusy;      // carrier sensed on the link
      logic collision;     // collision detector
      logic txPreamble;    // transmitter is in preamble or flag
      logic txFifoEmpty;   // tx_fifo holds nothing
      logic txLastSent;    // last byte has left the shifter
      logic rxActive;      // receiver is inside a frame
      logic rxFifoHasData; // a byte of this frame reached rx_fifo
      logic rxEof;         // end flag seen on a good frame
   } csb_link_in_t;
   typedef struct packed {
      logic txGrant;       // framer may send
      logic jamActive;     // framer sends jam
      logic jamLevel;      // line level during jam
      logic rxHalt;        // receiver must drop the frame
   } csb_link_out_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_SEND, ST_JAM, ST_BACKOFF, ST_RESWAIT
   } csb_state_t;
endpackage

// ### csb_slot_timer.sv
// bit and slot tick divider plus the eight-bit backoff down-counter
`timescale 1ns/10ps
`default_nettype none
module csb_slot_timer
   import csb_pkg::*;
#(
   parameter int BIT_DIV = 10,
   parameter int SLOT_BITS = 64
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // counter control
   input wire logic load,
   input wire logic [7:0] loadVal,
   input wire logic run,
   // ticks and state
   output logic bitTick,
   output logic zero,
   output logic [7:0] value
);
   // ==========================================================
   // dividers
   logic [15:0] divCnt_r, divCnt_nxt; // clocks within one bit
   logic [15:0] bitCnt_r, bitCnt_nxt; // bits within one slot
   logic bitTick_r, bitTick_nxt;
   logic slotTick_r, slotTick_nxt;
   logic [7:0] tmr_r, tmr_nxt;        // backoff count in slots

   // next values of dividers and counter
   always_comb begin
      divCnt_nxt = divCnt_r + 16'h0001;
      bitCnt_nxt = bitCnt_r;
      bitTick_nxt = 1'b0;
      slotTick_nxt = 1'b0;
      tmr_nxt = tmr_r;
      if (divCnt_r == 16'(BIT_DIV - 1)) begin
         divCnt_nxt = 16'h0000;
         bitTick_nxt = 1'b1;
         bitCnt_nxt = bitCnt_r + 16'h0001;
         if (bitCnt_r == 16'(SLOT_BITS - 1)) begin
            bitCnt_nxt = 16'h0000;
            slotTick_nxt = 1'b1;
         end
      end
      if (load) begin
         tmr_nxt = loadVal;
      end else if (run && slotTick_r && tmr_r != 8'h00) begin
         tmr_nxt = tmr_r - 8'h01;
      end
   end

   // registers only
   always_ff @(posedge clk) begin
      if (srst) begin
         divCnt_r <= 16'h0000;
         bitCnt_r <= 16'h0000;
         bitTick_r <= 1'b0;
         slotTick_r <= 1'b0;
         tmr_r <= 8'h00;
      end else begin
         divCnt_r <= divCnt_nxt;
         bitCnt_r <= bitCnt_nxt;
         bitTick_r <= bitTick_nxt;
         slotTick_r <= slotTick_nxt;
         tmr_r <= tmr_nxt;
      end
   end

   assign bitTick = bitTick_r;
   assign zero = (tmr_r == 8'h00);
   assign value = tmr_r;
endmodule // csb_slot_timer
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the collision backoff block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import csb_pkg::*;
   // ==========
   // bench state; short counts keep backoff waits small
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, g;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, txEnable, rxEnable, collisionIrq;
   logic coll = 0, fEmpty = 0, rxAct = 0, rxData = 0, rxEnd = 0;
   csb_link_in_t linkIn;
   csb_link_out_t linkOut;
   int failCount = 0, checksDone = 0;
   always #5 clk = ~clk;
   csb_collision_backoff #(.BIT_DIV(2), .SLOT_BITS(2)) dut_u (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .linkIn(linkIn), .linkOut(linkOut), .txEnable(txEnable),
      .rxEnable(rxEnable), .collisionIrq(collisionIrq));
   csb_link_model model_u (.clk(clk), .srst(srst), .collideReq(coll),
      .fifoEmpty(fEmpty), .rxAct(rxAct), .rxData(rxData),
      .rxEnd(rxEnd), .linkOut(linkOut), .linkIn(linkIn));
   // ==========
   // compare, verdict and bus tasks
   task automatic chk(input string nm, input logic [31:0] s, e);
      checksDone++;
      if (s !== e) begin
         $display("Error %s expected %h seen %h", nm, e, s);
         failCount++;
      end
   endtask
   task automatic wrapUp();
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // request held until pready is sampled high at an edge
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            return;
         end
      end
      chk("apb bound", 0, 1);
      wrapUp();
   endtask
   // bounded wait: 0 grant, 1 jam, 2 tx enable, 3 rx enable
   task automatic waitOn(input int k, input logic v);
      for (int i = 0; i < 4000; i++) begin
         @(posedge clk);
         if ((k == 0 ? linkOut.txGrant : k == 1 ? linkOut.jamActive :
               k == 2 ? txEnable : rxEnable) === v) return;
      end
      chk("wait bound", 0, 1);
      wrapUp();
   endtask
   task automatic pulseColl();
      coll <= 1'b1;
      @(posedge clk);
      coll <= 1'b0;
   endtask
   // ==========
   // main sequence
   initial begin
      void'($urandom(32'h856a));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      apb(0, CSB_CTRL_OFS, 0);
      chk("ctrl reset", rd, 0);
      apb(0, CSB_STAT_OFS, 0);
      chk("status reset", rd, 0);
      apb(1, 8'h18, 32'hffff);
      chk("unmapped error", {31'h0, err}, 1);
      apb(1, CSB_BKOFF_OFS, $urandom);
      chk("backoff write", {31'h0, err}, 0);
      apb(0, CSB_BKOFF_OFS, 0);
      chk("backoff kept", rd, 0);
      for (int n = 0; n < 4; n++) begin
         g = 8'($urandom_range(2, 6));
         apb(1, CSB_GAP_OFS, {24'h0, g});
         apb(0, CSB_GAP_OFS, 0);
         chk("gap readback", rd, {24'h0, g});
      end
      $display("registers test done");
      // preload count with a block of low ones
      apb(1, CSB_COLL_OFS, 32'h7f);
      apb(1, CSB_CTRL_OFS, 32'h39);
      waitOn(0, 1);
      pulseColl();
      waitOn(1, 1);
      waitOn(0, 1);
      apb(0, CSB_COLL_OFS, 0);
      chk("count shifted", rd, 32'hff);
      pulseColl();
      waitOn(2, 0);
      apb(0, CSB_STAT_OFS, 0);
      chk("overflow flag", rd, 1);
      chk("irq raised", {31'h0, collisionIrq}, 1);
      apb(1, CSB_STAT_OFS, 32'h1);
      apb(0, CSB_STAT_OFS, 0);
      chk("flag cleared", rd, 0);
      $display("early collision test done");
      // clear count before the next frame
      apb(1, CSB_COLL_OFS, 0);
      apb(1, CSB_CTRL_OFS, 32'h01);
      waitOn(0, 1);
      repeat (20) @(posedge clk);
      pulseColl();
      waitOn(2, 0);
      repeat (40) @(posedge clk);
      chk("no retry", {31'h0, linkOut.txGrant}, 0);
      chk("irq masked", {31'h0, collisionIrq}, 0);
      apb(0, CSB_STAT_OFS, 0);
      chk("late flag", rd, 1);
      $display("late collision test done");
      apb(1, CSB_STAT_OFS, 32'hf);
      apb(1, CSB_CTRL_OFS, 32'h01);
      waitOn(0, 1);
      fEmpty <= 1'b1;
      waitOn(2, 0);
      apb(0, CSB_STAT_OFS, 0);
      chk("tx done", rd, 32'h4);
      fEmpty <= 1'b0;
      apb(1, CSB_STAT_OFS, 32'h4);
      $display("success test done");
      // clear count, then a forced slot 0 with a level jam
      apb(1, CSB_COLL_OFS, 0);
      apb(1, CSB_SLOT_OFS, 32'hc0);
      apb(1, CSB_CTRL_OFS, 32'h19); // alternate with deterministic
      waitOn(0, 1);
      pulseColl();
      waitOn(1, 1);
      @(posedge clk);
      chk("jam level", {31'h0, linkOut.jamLevel}, 1);
      repeat (2) @(posedge clk);
      chk("jam level held", {31'h0, linkOut.jamLevel}, 1);
      waitOn(1, 0);
      repeat (150) @(posedge clk);
      chk("slot zero waits", {31'h0, linkOut.txGrant}, 0);
      // clearing tx enable drops the pending retry
      apb(1, CSB_CTRL_OFS, 32'h18);
      repeat (250) @(posedge clk);
      chk("retry aborted", {31'h0, linkOut.txGrant}, 0);
      $display("deterministic test done");
      apb(1, CSB_CTRL_OFS, 32'h02);
      rxAct <= 1'b1;
      pulseColl();
      @(posedge clk);
      chk("rx halt", {31'h0, linkOut.rxHalt}, 1);
      repeat (4) @(posedge clk);
      chk("rx kept", {31'h0, rxEnable}, 1);
      rxData <= 1'b1;
      pulseColl();
      waitOn(3, 0);
      apb(0, CSB_STAT_OFS, 0);
      chk("rx abort", rd, 32'h2);
      rxData <= 1'b0;
      apb(1, CSB_CTRL_OFS, 32'h00);
      apb(1, CSB_CTRL_OFS, 32'h02);
      rxEnd <= 1'b1;
      @(posedge clk);
      rxEnd <= 1'b0;
      waitOn(3, 0);
      apb(0, CSB_STAT_OFS, 0);
      chk("rx done", rd, 32'h8);
      $display("receive test done");
      wrapUp();
   end
endmodule // tb_top
`default_nettype wire
